// ===== hdl/pape_pkg.sv
/*
  Constants for the per-phase active power engine: register map, field
  positions, reset values and timing counts.
  Assumes a 25 MHz core clock and 24-bit signed sample words.
*/
package pape_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ            = 25_000_000;
  localparam int DSP_RATE_HZ       = 8_000;
  localparam int ACC_RATE_HZ       = 1_024_000;
  localparam logic [11:0] DSP_DIV_LAST = 12'(CLK_HZ / DSP_RATE_HZ - 1);
  localparam logic [14:0] ACC_FRAC_STEP = 15'(ACC_RATE_HZ / 1000);
  localparam logic [14:0] ACC_FRAC_MOD  = 15'(CLK_HZ / 1000);

  // Settling targets and the one-pole filter shifts derived from them
  localparam int LPF_LIGHT_SETTLE_MS  = 650;
  localparam int LPF_STRONG_SETTLE_MS = 1300;
  localparam int FUND_SETTLE_FULL_MS  = 875;
  localparam int FUND_SETTLE_PART_MS  = 375;
  localparam int SETTLE_TAUS          = 5;
  localparam logic [4:0] LPF_LIGHT_SHIFT =
    5'($clog2(LPF_LIGHT_SETTLE_MS * (DSP_RATE_HZ / 1000) / SETTLE_TAUS));
  localparam logic [4:0] LPF_STRONG_SHIFT =
    5'($clog2(LPF_STRONG_SETTLE_MS * (DSP_RATE_HZ / 1000) / SETTLE_TAUS));
  localparam logic [4:0] FUND_LPF_SHIFT =
    5'($clog2(FUND_SETTLE_FULL_MS * (DSP_RATE_HZ / 1000) / SETTLE_TAUS));

  // ==========================================================================
  // Datapath scaling
  localparam int PWR_SCALE_SHIFT = 20;
  localparam int INST_SHIFT      = 4;
  localparam int GAIN_FRAC_BITS  = 23;
  localparam int THR_ZERO_BITS   = 27;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] GAIN_ADDR [3] = '{16'h4399, 16'h439a, 16'h439b};
  localparam logic [15:0] TOS_ADDR  [3] = '{16'h439c, 16'h439d, 16'h439e};
  localparam logic [15:0] FOS_ADDR  [3] = '{16'h43a3, 16'h43a4, 16'h43a5};
  localparam logic [15:0] INST_ADDR [3] = '{16'he518, 16'he519, 16'he51a};
  localparam logic [15:0] LEVEL_ADDR    = 16'h43a2;
  localparam logic [15:0] STATUS_ADDR   = 16'he502;
  localparam logic [15:0] MASK_ADDR     = 16'he50a;
  localparam logic [15:0] CALCMODE_ADDR = 16'he60e;
  localparam logic [15:0] SIGN_ADDR     = 16'he617;
  localparam logic [15:0] CONFIG_ADDR   = 16'he618;
  localparam logic [15:0] MEASMODE_ADDR = 16'he700;
  localparam logic [15:0] THR_ADDR      = 16'hea02;

  // ==========================================================================
  // Field positions
  localparam int FILTER_STRENGTH_BIT = 5;
  localparam int GRID_FREQ_BIT       = 14;
  localparam int SIGN_MONITOR_BIT    = 0;
  localparam int REVERSE_LSB         = 6;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CALCMODE_RST = 16'h0000;
  localparam logic [15:0] CONFIG_RST   = 16'h0000;
  localparam logic [7:0]  MEASMODE_RST = 8'h00;
  localparam logic [7:0]  THR_RST      = 8'h03;

endpackage

// ===== hdl/pape_top.sv
/*
  Per-phase active power engine: multiply, low-pass filter, gain and offset
  calibration, first-stage energy accumulation and reverse-power detection,
  with the register file reached over a word register port.
  Assumes samples come from logic on CORE_CLK and are valid whenever
  DSP_TICK is high; the fundamental samples are already extracted outside.
*/
// Overview of operation
// - Each phase multiplies voltage by current, then low-pass filters the product.
// - Configuration bit picks light filter (650 ms) or strong filter (1300 ms) for total power; fundamental uses its own fixed filter.
// - Per-phase 24-bit read-only instantaneous power equals filtered power over 16.
// - Grid frequency bit selects 50 Hz (zero) or 60 Hz for fundamental power.
// - Nominal voltage level reads as 32-bit word, upper four bits zero.
// - Fundamental power settles within 375 ms partial, 875 ms full scale.
// - Filtered power is scaled by one plus signed gain over two to 23.
// - Same phase gain applies to every power datapath of that phase.
// - Separate signed offsets for total and fundamental power, added in filtered power LSBs (product over two to 20).
// - Gain and offset words sign extend to 28 bits, four zero bits above.
// - Mode bit picks total (zero) or fundamental power for sign monitoring.
// - Sign change checked only at first-stage pulses; sets phase reverse flag.
// - Phase sign bit updates with reverse flag: zero positive, one negative.
// - Masked reverse flag pulls interrupt low; writing one clears and releases.
// - First stage adds power at 1.024 MHz, pulses and subtracts at threshold.
// - Accumulated energy sign at pulse time is the power sign.
// - Threshold is eight-bit register value above 27 zero bits, shared.
`timescale 1ns/1ps

module pape_top import pape_pkg::*; (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Samples, three phases packed, phase A lowest
  input  wire logic [71:0] VOLT_SAMPLE,
  input  wire logic [71:0] CURR_SAMPLE,
  input  wire logic [71:0] FUND_VOLT_SAMPLE,
  input  wire logic [71:0] FUND_CURR_SAMPLE,
  // Register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // Status and configuration out
  output logic             IRQ_N,
  output logic             DSP_TICK,
  output logic      [2:0]  ENERGY_PULSE,
  output logic             GRID_FREQ_60,
  output logic      [27:0] NOMINAL_VOLTAGE
);

  // ==========================================================================
  // Registers and shared state
  logic signed [23:0] phase_power_gain [3];
  logic signed [23:0] total_power_offset [3];
  logic signed [23:0] fund_power_offset [3];
  logic        [27:0] nominal_voltage_level;
  logic        [15:0] computation_mode;
  logic        [15:0] dsp_config;
  logic        [7:0]  measurement_mode;
  logic        [7:0]  energy_threshold;
  logic        [2:0]  reverse_flag;
  logic        [2:0]  main_event_mask;
  logic        [2:0]  phase_power_sign;
  logic        [11:0] dsp_cnt;
  logic        [14:0] acc_frac;
  logic        [14:0] next_acc_frac;
  logic               acc_tick;
  logic        [5:0]  stage_pulse;
  logic        [5:0]  stage_sign;
  logic        [167:0] power_bus;
  logic        [2:0]  sign_event;
  logic               filter_strength_sel;
  logic               sign_monitor_sel;
  logic               status_wr;

  assign filter_strength_sel = dsp_config[FILTER_STRENGTH_BIT];
  assign sign_monitor_sel    = measurement_mode[SIGN_MONITOR_BIT];
  assign GRID_FREQ_60        = computation_mode[GRID_FREQ_BIT];
  assign NOMINAL_VOLTAGE     = nominal_voltage_level;
  assign status_wr           = REG_WR && (REG_ADDR == STATUS_ADDR);

  function automatic logic [31:0] sext_word(input logic [23:0] v);
    sext_word = {4'h0, {4{v[23]}}, v};
  endfunction

  // ==========================================================================
  // Rate generation
  assign DSP_TICK = (dsp_cnt == 12'h000);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dsp_cnt <= 12'h000;
    end else if (dsp_cnt == DSP_DIV_LAST) begin
      dsp_cnt <= 12'h000;
    end else begin
      dsp_cnt <= dsp_cnt + 12'h001;
    end
  end

  // Fractional divider: 25 MHz is no integer multiple of 1.024 MHz
  always_comb begin
    next_acc_frac = acc_frac + ACC_FRAC_STEP;
    if (next_acc_frac >= ACC_FRAC_MOD) begin
      next_acc_frac = next_acc_frac - ACC_FRAC_MOD;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      acc_frac <= 15'h0000;
      acc_tick <= 1'b0;
    end else begin
      acc_frac <= next_acc_frac;
      acc_tick <= (acc_frac + ACC_FRAC_STEP) >= ACC_FRAC_MOD;
    end
  end

  // ==========================================================================
  // Power datapath, index p*2+t, t=0 total, t=1 fundamental
  for (genvar p = 0; p < 3; p++) begin : g_phase
    for (genvar t = 0; t < 2; t++) begin : g_type
      logic signed [23:0] sv;
      logic signed [23:0] si;
      logic signed [47:0] prod;
      logic signed [27:0] praw;
      logic signed [43:0] lpf;
      logic        [4:0]  shf;
      logic signed [27:0] favg;
      logic signed [51:0] gprod;
      logic signed [27:0] next_pw;
      logic signed [27:0] pw;
      logic signed [39:0] thr;
      logic signed [39:0] eacc;
      logic signed [39:0] sum;
      logic signed [39:0] next_eacc;
      logic               hit;

      assign sv   = (t == 1) ? FUND_VOLT_SAMPLE[p*24 +: 24] : VOLT_SAMPLE[p*24 +: 24];
      assign si   = (t == 1) ? FUND_CURR_SAMPLE[p*24 +: 24] : CURR_SAMPLE[p*24 +: 24];
      assign prod = sv * si;
      assign praw = 28'(prod >>> PWR_SCALE_SHIFT);
      // Fundamental path uses its own fixed filter shift, equal to the light filter shift
      assign shf  = (t == 1) ? FUND_LPF_SHIFT :
                    (filter_strength_sel ? LPF_STRONG_SHIFT : LPF_LIGHT_SHIFT);

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          lpf <= 44'sh0;
        end else if (DSP_TICK) begin
          lpf <= lpf + (($signed({praw, 16'h0000}) - lpf) >>> shf);
        end
      end

      assign favg    = lpf[43:16];
      assign gprod   = favg * phase_power_gain[p];
      assign next_pw = favg + 28'(gprod >>> GAIN_FRAC_BITS)
                     + 28'((t == 1) ? fund_power_offset[p] : total_power_offset[p]);

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          pw <= 28'sh0;
        end else begin
          pw <= next_pw;
        end
      end

      // First stage: threshold magnitude either way keeps signed energy
      assign thr = $signed({5'h00, energy_threshold, 27'h0});
      assign sum = eacc + 40'(pw);

      always_comb begin
        hit       = 1'b0;
        next_eacc = sum;
        if (sum >= thr) begin
          hit       = 1'b1;
          next_eacc = sum - thr;
        end else if (sum <= -thr) begin
          hit       = 1'b1;
          next_eacc = sum + thr;
        end
      end

      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          eacc <= 40'sh0;
        end else if (acc_tick) begin
          eacc <= next_eacc;
        end
      end

      assign stage_pulse[p*2+t] = acc_tick && hit;
      assign stage_sign[p*2+t]  = sum[39];
      assign power_bus[(p*2+t)*28 +: 28] = pw;
    end

    assign sign_event[p] = stage_pulse[p*2 + int'(sign_monitor_sel)] &&
                           (stage_sign[p*2 + int'(sign_monitor_sel)] != phase_power_sign[p]);
    assign ENERGY_PULSE[p] = stage_pulse[p*2 + int'(sign_monitor_sel)];

    // ------------------------------------------------------------------------
    property p_flag_set;
      @(posedge CORE_CLK) disable iff (RST)
      sign_event[p] |=> reverse_flag[p];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("reverse flag missed");
    property p_sign_upd;
      @(posedge CORE_CLK) disable iff (RST)
      sign_event[p] |=> phase_power_sign[p] == $past(stage_sign[p*2 + int'(sign_monitor_sel)]);
    endproperty
    a_sign_upd: assert property (p_sign_upd) else $error("sign bit wrong");
    property p_irq_low;
      @(posedge CORE_CLK) disable iff (RST)
      sign_event[p] && main_event_mask[p] |=> !IRQ_N;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt not raised");
    property p_w1c;
      @(posedge CORE_CLK) disable iff (RST)
      status_wr && REG_WDATA[REVERSE_LSB+p] && !sign_event[p] |=> !reverse_flag[p];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");
    property p_only_at_pulse;
      @(posedge CORE_CLK) disable iff (RST)
      !$past(ENERGY_PULSE[p]) && !$past(status_wr) |-> $stable(phase_power_sign[p]);
    endproperty
    a_only_at_pulse: assert property (p_only_at_pulse) else $error("sign moved");
  end

  // ==========================================================================
  // Reverse-power flags and sign bits, set wins over clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      reverse_flag <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (sign_event[k]) begin
          reverse_flag[k] <= 1'b1;
        end else if (status_wr && REG_WDATA[REVERSE_LSB+k]) begin
          reverse_flag[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_power_sign <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (sign_event[k]) begin
          phase_power_sign[k] <= stage_sign[k*2 + int'(sign_monitor_sel)];
        end
      end
    end
  end

  assign IRQ_N = !(|(reverse_flag & main_event_mask));

  // ==========================================================================
  // Register writes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int k = 0; k < 3; k++) begin
        phase_power_gain[k]   <= 24'sh0;
        total_power_offset[k] <= 24'sh0;
        fund_power_offset[k]  <= 24'sh0;
      end
    end else if (REG_WR) begin
      for (int k = 0; k < 3; k++) begin
        if (REG_ADDR == GAIN_ADDR[k]) begin
          phase_power_gain[k] <= REG_WDATA[23:0];
        end
        if (REG_ADDR == TOS_ADDR[k]) begin
          total_power_offset[k] <= REG_WDATA[23:0];
        end
        if (REG_ADDR == FOS_ADDR[k]) begin
          fund_power_offset[k] <= REG_WDATA[23:0];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      nominal_voltage_level <= 28'h0;
      computation_mode      <= CALCMODE_RST;
      dsp_config            <= CONFIG_RST;
      measurement_mode      <= MEASMODE_RST;
      energy_threshold      <= THR_RST;
      main_event_mask       <= 3'h0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        LEVEL_ADDR:    nominal_voltage_level <= REG_WDATA[27:0];
        CALCMODE_ADDR: computation_mode      <= REG_WDATA[15:0];
        CONFIG_ADDR:   dsp_config            <= REG_WDATA[15:0];
        MEASMODE_ADDR: measurement_mode      <= REG_WDATA[7:0];
        THR_ADDR:      energy_threshold      <= REG_WDATA[7:0];
        MASK_ADDR:     main_event_mask       <= REG_WDATA[REVERSE_LSB+2:REVERSE_LSB];
        default:       nominal_voltage_level <= nominal_voltage_level;
      endcase
    end
  end

  // ==========================================================================
  // Register reads, answered one cycle after REG_RD
  function automatic logic [31:0] read_word(input logic [15:0] a);
    logic [27:0] pwk;
    read_word = 32'h0;
    pwk       = 28'h0;
    case (a)
      LEVEL_ADDR:    read_word = {4'h0, nominal_voltage_level};
      STATUS_ADDR:   read_word = {23'h0, reverse_flag, 6'h00};
      MASK_ADDR:     read_word = {23'h0, main_event_mask, 6'h00};
      CALCMODE_ADDR: read_word = {16'h0, computation_mode};
      SIGN_ADDR:     read_word = {29'h0, phase_power_sign};
      CONFIG_ADDR:   read_word = {16'h0, dsp_config};
      MEASMODE_ADDR: read_word = {24'h0, measurement_mode};
      THR_ADDR:      read_word = {24'h0, energy_threshold};
      default:       read_word = 32'h0;
    endcase
    for (int k = 0; k < 3; k++) begin
      pwk = power_bus[(k*2)*28 +: 28];
      if (a == GAIN_ADDR[k]) read_word = sext_word(phase_power_gain[k]);
      if (a == TOS_ADDR[k])  read_word = sext_word(total_power_offset[k]);
      if (a == FOS_ADDR[k])  read_word = sext_word(fund_power_offset[k]);
      if (a == INST_ADDR[k]) read_word = {8'h0, pwk[27:INST_SHIFT]};
    end
  endfunction

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      REG_RDATA <= read_word(REG_ADDR);
    end
  end

  // ==========================================================================
  // Checks
  property p_sign_read;
    @(posedge CORE_CLK) disable iff (RST)
    REG_RD && REG_ADDR == SIGN_ADDR |=> REG_RDATA == {29'h0, $past(phase_power_sign)};
  endproperty
  a_sign_read: assert property (p_sign_read) else $error("sign read wrong");
  property p_level_pad;
    @(posedge CORE_CLK) disable iff (RST)
    REG_RD && REG_ADDR == LEVEL_ADDR |=> REG_RDATA[31:28] == 4'h0;
  endproperty
  a_level_pad: assert property (p_level_pad) else $error("level pad wrong");
  property p_gain_pad;
    @(posedge CORE_CLK) disable iff (RST)
    REG_RD && REG_ADDR == GAIN_ADDR[0]
      |=> REG_RDATA[31:24] == {4'h0, {4{$past(phase_power_gain[0][23])}}};
  endproperty
  a_gain_pad: assert property (p_gain_pad) else $error("gain pad wrong");
  property p_acc_spacing;
    @(posedge CORE_CLK) disable iff (RST)
    acc_tick |=> !acc_tick [*8];
  endproperty
  a_acc_spacing: assert property (p_acc_spacing) else $error("stage tick too fast");
  property p_lpf_hold;
    @(posedge CORE_CLK) disable iff (RST)
    !DSP_TICK |=> $stable(g_phase[0].g_type[0].lpf);
  endproperty
  a_lpf_hold: assert property (p_lpf_hold) else $error("filter moved off tick");

endmodule

// ===== sim/tb.sv
/*
  Self-checking bench for the per-phase active power engine: register
  reset values and access kinds, word packing, reverse-power events,
  interrupt masking and clearing, and the choice of monitored power.
  Assumes pape_pkg and pape_top from hdl/ and a 25 MHz CORE_CLK.
*/
`timescale 1ns/1ps

module tb import pape_pkg::*;;

  // ==========================================================================
  // Signals
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } pape_row_t;

  logic        CORE_CLK         = 1'b0;
  logic        RST              = 1'b1;
  logic [71:0] VOLT_SAMPLE      = 72'h0;
  logic [71:0] CURR_SAMPLE      = 72'h0;
  logic [71:0] FUND_VOLT_SAMPLE = 72'h0;
  logic [71:0] FUND_CURR_SAMPLE = 72'h0;
  logic [15:0] REG_ADDR         = 16'h0;
  logic        REG_WR           = 1'b0;
  logic        REG_RD           = 1'b0;
  logic [31:0] REG_WDATA        = 32'h0;
  logic [31:0] REG_RDATA;
  logic        IRQ_N;
  logic        DSP_TICK;
  logic [2:0]  ENERGY_PULSE;
  logic        GRID_FREQ_60;
  logic [27:0] NOMINAL_VOLTAGE;
  int          err_total        = 0;
  int          n_compared       = 0;

  // Reset reads first, then write and read back
  pape_row_t rows [15] = '{
    '{THR_ADDR, 1'b0, 32'h0, 32'h00000003},
    '{CONFIG_ADDR, 1'b0, 32'h0, 32'h0},
    '{CALCMODE_ADDR, 1'b0, 32'h0, 32'h0},
    '{MEASMODE_ADDR, 1'b0, 32'h0, 32'h0},
    '{STATUS_ADDR, 1'b0, 32'h0, 32'h0},
    '{SIGN_ADDR, 1'b0, 32'h0, 32'h0},
    '{GAIN_ADDR[0], 1'b1, 32'h00c00000, 32'h0fc00000},
    '{GAIN_ADDR[1], 1'b1, 32'h00400000, 32'h00400000},
    '{TOS_ADDR[2], 1'b1, 32'h00800001, 32'h0f800001},
    '{FOS_ADDR[0], 1'b1, 32'h007fffff, 32'h007fffff},
    '{LEVEL_ADDR, 1'b1, 32'hf7ffffff, 32'h07ffffff},
    '{CALCMODE_ADDR, 1'b1, 32'h00004000, 32'h00004000},
    '{CONFIG_ADDR, 1'b1, 32'h00000020, 32'h00000020},
    '{INST_ADDR[1], 1'b1, 32'h00000123, 32'h0},
    '{16'h1234, 1'b1, 32'hffffffff, 32'h0}
  };

  always #20 CORE_CLK = ~CORE_CLK;

  pape_top dut (
    .CORE_CLK         (CORE_CLK),
    .RST              (RST),
    .VOLT_SAMPLE      (VOLT_SAMPLE),
    .CURR_SAMPLE      (CURR_SAMPLE),
    .FUND_VOLT_SAMPLE (FUND_VOLT_SAMPLE),
    .FUND_CURR_SAMPLE (FUND_CURR_SAMPLE),
    .REG_ADDR         (REG_ADDR),
    .REG_WR           (REG_WR),
    .REG_RD           (REG_RD),
    .REG_WDATA        (REG_WDATA),
    .REG_RDATA        (REG_RDATA),
    .IRQ_N            (IRQ_N),
    .DSP_TICK         (DSP_TICK),
    .ENERGY_PULSE     (ENERGY_PULSE),
    .GRID_FREQ_60     (GRID_FREQ_60),
    .NOMINAL_VOLTAGE  (NOMINAL_VOLTAGE)
  );

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // Bounded: a stuck accumulator shows up as a zero pulse value
  task automatic wait_pulse(output logic [2:0] seen);
    int k;
    k    = 0;
    seen = 3'b000;
    while (seen === 3'b000 && k < 40000) begin
      @(posedge CORE_CLK);
      #1 seen = ENERGY_PULSE;
      k++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [2:0]  pl;
    int          n;
    repeat (12) @(posedge CORE_CLK);
    chk("tick in reset", 32'h1, 32'(DSP_TICK));
    chk("irq in reset", 32'h1, 32'(IRQ_N));
    RST <= 1'b0;
    #1 n = 0;
    do begin
      @(posedge CORE_CLK);
      #1 n++;
    end while (DSP_TICK !== 1'b1 && n < 4000);
    chk("tick period", 32'h00000c35, 32'(n));
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        reg_wr(rows[i].addr, rows[i].wdata);
      end
      reg_rd(rows[i].addr, rd);
      chk($sformatf("reg %h", rows[i].addr), rows[i].exp, rd);
    end
    chk("grid select", 32'h1, 32'(GRID_FREQ_60));
    chk("nominal level", 32'h07ffffff, 32'(NOMINAL_VOLTAGE));
    // Second reset mid-run also clears the skewed calibration above
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    reg_rd(GAIN_ADDR[0], rd);
    chk("gain after reset", 32'h0, rd);
    chk("grid after reset", 32'h0, 32'(GRID_FREQ_60));
    // Lowest threshold so a few ticks of full-scale power suffice
    reg_wr(THR_ADDR, 32'h00000001);
    reg_wr(MASK_ADDR, 32'h00000040);
    VOLT_SAMPLE      <= {3{24'h7fffff}};
    CURR_SAMPLE      <= {3{24'h800000}};
    FUND_VOLT_SAMPLE <= {3{24'h7fffff}};
    FUND_CURR_SAMPLE <= {3{24'h7fffff}};
    wait_pulse(pl);
    chk("total pulses", 32'h7, 32'(pl));
    @(posedge CORE_CLK);
    #1 chk("irq on reverse", 32'h0, 32'(IRQ_N));
    reg_rd(STATUS_ADDR, rd);
    chk("reverse flags", 32'h7, 32'(rd[8:6]));
    reg_rd(SIGN_ADDR, rd);
    chk("sign bits", 32'h7, 32'(rd[2:0]));
    reg_rd(INST_ADDR[0], rd);
    chk("inst power top", 32'h1, 32'(rd[31:23]));
    reg_wr(STATUS_ADDR, 32'h00000040);
    #1 chk("irq after clear", 32'h1, 32'(IRQ_N));
    reg_rd(STATUS_ADDR, rd);
    chk("flags after clear", 32'h6, 32'(rd[8:6]));
    // Host sets a positive nominal level before trusting fundamental power
    reg_wr(LEVEL_ADDR, 32'h003d0900);
    #1 chk("level before fund", 32'h003d0900, 32'(NOMINAL_VOLTAGE));
    // Fundamental power is positive, so monitoring it flips every sign
    reg_wr(STATUS_ADDR, 32'h00000180);
    reg_wr(MEASMODE_ADDR, 32'h00000001);
    wait_pulse(pl);
    chk("fund pulses", 32'h7, 32'(pl));
    @(posedge CORE_CLK);
    reg_rd(SIGN_ADDR, rd);
    chk("fund sign bits", 32'h0, 32'(rd[2:0]));
    reg_rd(STATUS_ADDR, rd);
    chk("fund flags", 32'h7, 32'(rd[8:6]));
    end_of_test();
  end

  // ==========================================================================
  // Watchdog, well past the expected run of about 40k cycles
  initial begin
    repeat (60000) @(posedge CORE_CLK);
    err_total++;
    $display("unexpected watchdog: expected finish, seen timeout");
    end_of_test();
  end

endmodule
